// [common/fbc_cfg.svh]
// Constants for the flash erase, write and bank control block.
`ifndef FBC_CFG_SVH
`define FBC_CFG_SVH

// ****************************************
// Device special register map
// ****************************************
`define FBC_SFR_ERASE 16'h0094
`define FBC_SFR_FCTL 16'h00B2
`define FBC_SFR_BANK 16'h00B6
`define FBC_SFR_PGADR 16'h00B7
`define FBC_IO_UNLOCK 16'h2702

// ****************************************
// Field positions
// ****************************************
`define FBC_PWE_BIT 0
`define FBC_MEEN_BIT 1
`define FBC_PSTWR_BIT 2
`define FBC_PEND_BIT 3
`define FBC_PGADR_LSB 2
`define FBC_UNLOCK_LSB 4

// ****************************************
// Reset values and codes
// ****************************************
`define FBC_BANK_RST 2'h1
`define FBC_CMD_PAGE 8'h55
`define FBC_CMD_MASS 8'hAA
`define FBC_UNLOCK_KEY 4'h2
`define FBC_WINDOW_BIT 15

// ****************************************
// Bridge APB register map
// ****************************************
`define FBC_APB_ADDR 12'h000
`define FBC_APB_WDATA 12'h004
`define FBC_APB_CTRL 12'h008
`define FBC_APB_CMD 12'h00C
`define FBC_APB_RESULT 12'h010
`define FBC_APB_PHYS 12'h014

`endif

// [common/fbc_if.sv]
// Link between the core bridge and the flash control logic.
`timescale 1ns/10ps
interface fbc_if;
  logic sfr_wr;
  logic sfr_rd;
  logic [15:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic store;
  logic [15:0] store_addr;
  logic [7:0] store_data;
  logic int_enabled;
  logic [15:0] code_addr;
  logic [16:0] phys_addr;

  modport dev
  (
    input sfr_wr, sfr_rd, sfr_addr, sfr_wdata, store, store_addr,
    input store_data, int_enabled, code_addr,
    output sfr_rdata, phys_addr
  );

  modport core
  (
    output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, store, store_addr,
    output store_data, int_enabled, code_addr,
    input sfr_rdata, phys_addr
  );
endinterface : fbc_if

// [common/fbc_pkg.sv]
// Types used by the core bridge end of the flash control link.
package fbc_pkg;

  typedef enum logic [1:0]
  {
    FBC_OP_SFR_WR,
    FBC_OP_SFR_RD,
    FBC_OP_STORE,
    FBC_OP_FETCH
  } fbc_op_t;

  typedef enum
  {
    FBC_ST_IDLE,
    FBC_ST_ISSUE,
    FBC_ST_WAIT
  } fbc_state_t;

endpackage : fbc_pkg

// [src/fbc_core_bridge.sv]
// Core-side bridge driving the flash control link from APB.
`timescale 1ns/10ps
`include "fbc_cfg.svh"
module fbc_core_bridge
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  fbc_if.core link
);

  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic ien_q;
  fbc_pkg::fbc_op_t op_q;
  fbc_pkg::fbc_state_t state_q;
  logic [7:0] rdata_q;
  logic [16:0] phys_q;
  logic wr_acc;
  logic mapped;

  assign wr_acc = psel && penable && pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == `FBC_APB_ADDR) || (paddr == `FBC_APB_WDATA) ||
                  (paddr == `FBC_APB_CTRL) || (paddr == `FBC_APB_CMD) ||
                  (paddr == `FBC_APB_RESULT) || (paddr == `FBC_APB_PHYS);
  assign pslverr = psel && penable && !mapped;

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      ien_q <= 1'b0;
    end
    else if (wr_acc)
    begin
      if (paddr == `FBC_APB_ADDR)
        addr_q <= pwdata[15:0];
      if (paddr == `FBC_APB_WDATA)
        wdata_q <= pwdata[7:0];
      if (paddr == `FBC_APB_CTRL)
        ien_q <= pwdata[0];
    end
  end

  // R15: software loads key first
  // R5: command strobes follow software order
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= fbc_pkg::FBC_ST_IDLE;
      op_q <= fbc_pkg::FBC_OP_SFR_WR;
    end
    else
    begin
      case (state_q)
        fbc_pkg::FBC_ST_IDLE:
          if (wr_acc && paddr == `FBC_APB_CMD)
          begin
            op_q <= fbc_pkg::fbc_op_t'(pwdata[1:0]);
            state_q <= fbc_pkg::FBC_ST_ISSUE;
          end
        fbc_pkg::FBC_ST_ISSUE:
          state_q <= fbc_pkg::FBC_ST_WAIT;
        fbc_pkg::FBC_ST_WAIT:
          state_q <= fbc_pkg::FBC_ST_IDLE;
        default:
          state_q <= fbc_pkg::FBC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      link.sfr_wr <= 1'b0;
      link.sfr_rd <= 1'b0;
      link.store <= 1'b0;
    end
    else
    begin
      link.sfr_wr <= wr_acc && paddr == `FBC_APB_CMD &&
                     state_q == fbc_pkg::FBC_ST_IDLE &&
                     pwdata[1:0] == 2'h0;
      link.sfr_rd <= wr_acc && paddr == `FBC_APB_CMD &&
                     state_q == fbc_pkg::FBC_ST_IDLE &&
                     pwdata[1:0] == 2'h1;
      link.store <= wr_acc && paddr == `FBC_APB_CMD &&
                    state_q == fbc_pkg::FBC_ST_IDLE &&
                    pwdata[1:0] == 2'h2;
    end
  end

  assign link.sfr_addr = addr_q;
  assign link.sfr_wdata = wdata_q;
  assign link.store_addr = addr_q;
  assign link.store_data = wdata_q;
  assign link.code_addr = addr_q;
  assign link.int_enabled = ien_q;

  // ****************************************
  // Result capture and read mux
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_q <= 8'h00;
      phys_q <= 17'h0_0000;
    end
    else if (state_q == fbc_pkg::FBC_ST_WAIT)
    begin
      if (op_q == fbc_pkg::FBC_OP_SFR_RD)
        rdata_q <= link.sfr_rdata;
      phys_q <= link.phys_addr;
    end
  end

  always_comb
  begin
    prdata = 32'h0000_0000;
    case (paddr)
      `FBC_APB_ADDR:
        prdata = {16'h0000, addr_q};
      `FBC_APB_WDATA:
        prdata = {24'h00_0000, wdata_q};
      `FBC_APB_CTRL:
        prdata = {31'h0000_0000, ien_q};
      `FBC_APB_RESULT:
        prdata = {23'h00_0000, state_q != fbc_pkg::FBC_ST_IDLE, rdata_q};
      `FBC_APB_PHYS:
        prdata = {15'h0000, phys_q};
      default:
        prdata = 32'h0000_0000;
    endcase
  end

endmodule : fbc_core_bridge

// [src/fbc_flash_ctrl.sv]
// Flash erase, posted write and code bank control logic.
// Function
// R1: Bank select maps 32 KB into upper half.
// R2: Lower half always maps fixed region.
// R3: Bank zero mirrors the lower bank.
// R4: Bank n reaches offset n times 0x8000.
// R5: Code 0x55 starts page erase after address.
// R6: Code 0xAA mass erases when enabled, debug on.
// R7: Other erase codes are ignored.
// R8: Mass enable authorises only one erase.
// R9: Page address is bits 7 to 2.
// R10: Page address rewritten before each page erase.
// R11: Pending flag set; further writes dropped.
// R12: Posted write runs when engine busy falls.
// R13: Without posting, writes run at once.
// R14: Write enable stores bytes, self clears.
// R15: Modification allowed only with unlock key 2.
`timescale 1ns/10ps
`include "fbc_cfg.svh"
module fbc_flash_ctrl
(
  input wire logic clk,
  input wire logic rst,
  fbc_if.dev link,
  input wire logic engine_enable,
  input wire logic engine_busy,
  input wire logic debug_port_enable,
  output logic page_erase,
  output logic mass_erase,
  output logic [5:0] erase_page,
  output logic flash_write,
  output logic [16:0] flash_write_addr,
  output logic [7:0] flash_write_data
);

  logic [1:0] bank_q;
  logic [5:0] pgadr_q;
  logic pg_armed_q;
  logic meen_q;
  logic pstwr_q;
  logic pwe_q;
  logic [3:0] unlock_q;
  logic pend_q;
  logic [16:0] pend_addr_q;
  logic [7:0] pend_data_q;
  logic busy_q;
  logic [7:0] rdata_q;
  logic unlocked;
  logic flash_store;
  logic busy_fall;
  logic erase_wr;

  // Maps a code address to the physical flash offset.
  function automatic logic [16:0] map_addr(input logic [15:0] a,
                                           input logic [1:0] bank);
    // R1: upper window banked
    // R2: lower half fixed
    // R3: bank zero mirror
    // R4: offset n times window
    if (a[`FBC_WINDOW_BIT])
      map_addr = {bank, a[14:0]};
    else
      map_addr = {2'h0, a[14:0]};
  endfunction : map_addr

  // R15: unlock key check
  assign unlocked = (unlock_q == `FBC_UNLOCK_KEY);
  // R14: store goes to flash
  assign flash_store = link.store && pwe_q;
  assign busy_fall = busy_q && !engine_busy;
  assign erase_wr = link.sfr_wr && (link.sfr_addr == `FBC_SFR_ERASE);

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
      bank_q <= `FBC_BANK_RST;
    else if (link.sfr_wr && link.sfr_addr == `FBC_SFR_BANK)
      bank_q <= link.sfr_wdata[1:0];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      unlock_q <= 4'h0;
    else if (link.sfr_wr && link.sfr_addr == `FBC_IO_UNLOCK)
      unlock_q <= link.sfr_wdata[`FBC_UNLOCK_LSB +: 4];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      pstwr_q <= 1'b0;
    else if (link.sfr_wr && link.sfr_addr == `FBC_SFR_FCTL)
      pstwr_q <= link.sfr_wdata[`FBC_PSTWR_BIT];
  end

  // R9: page field bits 7 to 2
  always_ff @(posedge clk)
  begin
    if (rst)
      pgadr_q <= 6'h00;
    else if (link.sfr_wr && link.sfr_addr == `FBC_SFR_PGADR)
      pgadr_q <= link.sfr_wdata[`FBC_PGADR_LSB +: 6];
  end

  // R10: page address consumed
  always_ff @(posedge clk)
  begin
    if (rst)
      pg_armed_q <= 1'b0;
    else if (link.sfr_wr && link.sfr_addr == `FBC_SFR_PGADR)
      pg_armed_q <= 1'b1;
    else if (erase_wr && link.sfr_wdata == `FBC_CMD_PAGE)
      pg_armed_q <= 1'b0;
  end

  // R8: mass enable consumed
  always_ff @(posedge clk)
  begin
    if (rst)
      meen_q <= 1'b0;
    else if (link.sfr_wr && link.sfr_addr == `FBC_SFR_FCTL)
      meen_q <= link.sfr_wdata[`FBC_MEEN_BIT];
    else if (erase_wr && link.sfr_wdata == `FBC_CMD_MASS)
      meen_q <= 1'b0;
  end

  // R14: write enable, blocked, self clearing
  always_ff @(posedge clk)
  begin
    if (rst)
      pwe_q <= 1'b0;
    else if (link.sfr_wr && link.sfr_addr == `FBC_SFR_FCTL &&
             !link.int_enabled)
      pwe_q <= link.sfr_wdata[`FBC_PWE_BIT];
    else if (flash_store)
      pwe_q <= 1'b0;
  end

  // ****************************************
  // Erase start
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      page_erase <= 1'b0;
      mass_erase <= 1'b0;
      erase_page <= 6'h00;
    end
    else
    begin
      // R5: page erase code
      // R7: other codes ignored
      page_erase <= erase_wr && link.sfr_wdata == `FBC_CMD_PAGE &&
                    pg_armed_q && unlocked;
      // R6: mass erase code
      mass_erase <= erase_wr && link.sfr_wdata == `FBC_CMD_MASS &&
                    meen_q && debug_port_enable && unlocked;
      erase_page <= pgadr_q;
    end
  end

  // ****************************************
  // Flash write path
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
      busy_q <= 1'b0;
    else
      busy_q <= engine_busy;
  end

  // R11: pending flag
  // R12: one entry queue
  always_ff @(posedge clk)
  begin
    if (rst)
      pend_q <= 1'b0;
    else if (flash_store && unlocked && pstwr_q && engine_enable &&
             !pend_q)
      pend_q <= 1'b1;
    else if (busy_fall)
      pend_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pend_addr_q <= 17'h0_0000;
      pend_data_q <= 8'h00;
    end
    else if (flash_store && !pend_q)
    begin
      pend_addr_q <= map_addr(link.store_addr, bank_q);
      pend_data_q <= link.store_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flash_write <= 1'b0;
      flash_write_addr <= 17'h0_0000;
      flash_write_data <= 8'h00;
    end
    else if (pend_q && busy_fall)
    begin
      // R12: execute on busy fall
      flash_write <= 1'b1;
      flash_write_addr <= pend_addr_q;
      flash_write_data <= pend_data_q;
    end
    else if (flash_store && unlocked && !pend_q &&
             !(pstwr_q && engine_enable))
    begin
      // R13: immediate write
      flash_write <= 1'b1;
      flash_write_addr <= map_addr(link.store_addr, bank_q);
      flash_write_data <= link.store_data;
    end
    else
      flash_write <= 1'b0;
  end

  // ****************************************
  // Read back and code mapping
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_q <= 8'h00;
    else if (link.sfr_rd)
    begin
      case (link.sfr_addr)
        `FBC_SFR_FCTL:
          rdata_q <= {4'h0, pend_q, pstwr_q, 1'b0, pwe_q};
        `FBC_SFR_BANK:
          rdata_q <= {6'h00, bank_q};
        `FBC_IO_UNLOCK:
          rdata_q <= {unlock_q, 4'h0};
        default:
          rdata_q <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      link.phys_addr <= 17'h0_0000;
    else
      link.phys_addr <= map_addr(link.code_addr, bank_q);
  end

  assign link.sfr_rdata = rdata_q;

endmodule : fbc_flash_ctrl

// [verification/fbc_assertions.sv]
// Checker for the flash control link and its output pulses.
`timescale 1ns/10ps
module fbc_assertions
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sfr_wr,
  input wire logic [15:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic store,
  input wire logic [7:0] store_data,
  input wire logic [15:0] code_addr,
  input wire logic [16:0] phys_addr,
  input wire logic debug_port_enable,
  input wire logic engine_busy,
  input wire logic page_erase,
  input wire logic mass_erase,
  input wire logic flash_write,
  input wire logic [7:0] flash_write_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ****************
  // Checks
  // ****************
  pe_pulse_a: assert property (page_erase |=> !page_erase)
    else $error("page erase wider than one cycle");
  pe_cause_a: assert property (page_erase |-> $past(sfr_wr
    && sfr_addr == 16'h0094 && sfr_wdata == 8'h55))
    else $error("page erase without its code");
  me_cause_a: assert property (mass_erase |-> $past(sfr_wr
    && sfr_addr == 16'h0094 && sfr_wdata == 8'haa && debug_port_enable))
    else $error("mass erase without its cause");
  bad_code_a: assert property (sfr_wr && sfr_addr == 16'h0094
    && sfr_wdata != 8'h55 && sfr_wdata != 8'haa |=> !page_erase
    && !mass_erase) else $error("erase from unknown code");
  lo_map_a: assert property (!code_addr[15]
    |=> phys_addr == {1'b0, $past(code_addr)})
    else $error("lower half not fixed");
  hi_map_a: assert property (code_addr[15]
    |=> phys_addr[14:0] == $past(code_addr[14:0]))
    else $error("upper window offset wrong");
  fw_src_a: assert property (flash_write |-> $past(store)
    || ($past(engine_busy, 2) && !$past(engine_busy)))
    else $error("flash write without cause");
  fw_data_a: assert property (flash_write && $past(store)
    && !($past(engine_busy, 2) && !$past(engine_busy))
    |-> flash_write_data == $past(store_data))
    else $error("immediate write data wrong");
endmodule : fbc_assertions

// [verification/test_flash_erase_write_bank_control.sv]
// Bench driving both link ends over APB.
`timescale 1ns/10ps
module test_flash_erase_write_bank_control;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, ee = 0, eb = 0, dbg = 1, pe, me, fw;
  logic [5:0] pg;
  logic [16:0] fa;
  logic [7:0] fd;
  int mismatches = 0, checks = 0, npe = 0, nme = 0, nfw = 0;
  fbc_if link ();
  fbc_core_bridge fbc_core_bridge_inst (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  fbc_flash_ctrl fbc_flash_ctrl_inst (.clk(clk), .rst(rst),
    .link(link), .engine_enable(ee), .engine_busy(eb),
    .debug_port_enable(dbg), .page_erase(pe), .mass_erase(me),
    .erase_page(pg), .flash_write(fw), .flash_write_addr(fa),
    .flash_write_data(fd));
  fbc_assertions fbc_assertions_inst (.clk(clk), .rst(rst),
    .sfr_wr(link.sfr_wr), .sfr_addr(link.sfr_addr),
    .sfr_wdata(link.sfr_wdata), .store(link.store),
    .store_data(link.store_data), .code_addr(link.code_addr),
    .phys_addr(link.phys_addr), .debug_port_enable(dbg),
    .engine_busy(eb), .page_erase(pe), .mass_erase(me),
    .flash_write(fw), .flash_write_data(fd));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    npe <= npe + (pe === 1'b1);
    nme <= nme + (me === 1'b1);
    nfw <= nfw + (fw === 1'b1);
  end
  // ****************
  // Tasks
  // ****************
  task complete_run;
    if (mismatches == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask : apb
  task cmd(input logic [15:0] a, input logic [7:0] d, input logic [1:0] c);
    apb(1, 12'h000, {16'h0000, a});
    apb(1, 12'h004, {24'h00_0000, d});
    apb(1, 12'h00c, {30'h0000_0000, c});
    repeat (4) @(posedge clk);
  endtask : cmd
  task rd(input logic [15:0] a, input logic [31:0] e);
    cmd(a, 8'h00, 2'h1);
    apb(0, 12'h010, 32'h0000_0000);
    chk(r & 32'h0000_00ff, e);
  endtask : rd
  task t_map;
    rd(16'h00b6, 32'h0000_0001);
    for (int b = 0; b < 4; b++)
    begin
      cmd(16'h00b6, 8'(b), 2'h0);
      cmd(16'h8123, 8'h00, 2'h3);
      apb(0, 12'h014, 32'h0000_0000);
      chk(r, 32'(b) * 32'h0000_8000 + 32'h0000_0123);
    end
    cmd(16'h0123, 8'h00, 2'h3);
    apb(0, 12'h014, 32'h0000_0000);
    chk(r, 32'h0000_0123);
    apb(0, 12'h020, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
  endtask : t_map
  task t_erase;
    cmd(16'h00b7, 8'hfc, 2'h0);
    cmd(16'h0094, 8'h55, 2'h0);
    chk(npe, 32'h0000_0000);
    cmd(16'h2702, 8'h20, 2'h0);
    cmd(16'h00b7, 8'hfc, 2'h0);
    cmd(16'h0094, 8'h55, 2'h0);
    chk(npe, 32'h0000_0001);
    chk({26'h0, pg}, 32'h0000_003f);
    cmd(16'h0094, 8'h55, 2'h0);
    chk(npe, 32'h0000_0001);
    cmd(16'h0094, 8'h12, 2'h0);
    chk(npe + nme, 32'h0000_0001);
    cmd(16'h00b2, 8'h02, 2'h0);
    cmd(16'h0094, 8'haa, 2'h0);
    chk(nme, 32'h0000_0001);
    cmd(16'h0094, 8'haa, 2'h0);
    chk(nme, 32'h0000_0001);
  endtask : t_erase
  task t_post;
    ee <= 1;
    eb <= 1;
    cmd(16'h00b2, 8'h05, 2'h0);
    cmd(16'h0040, 8'h5a, 2'h2);
    chk(nfw, 32'h0000_0000);
    rd(16'h00b2, 32'h0000_000c);
    cmd(16'h00b2, 8'h05, 2'h0);
    cmd(16'h0041, 8'h77, 2'h2);
    eb <= 0;
    repeat (3) @(posedge clk);
    chk(nfw, 32'h0000_0001);
    chk({15'h0, fa}, 32'h0000_0040);
    chk({24'h0, fd}, 32'h0000_005a);
    ee <= 0;
    cmd(16'h00b2, 8'h05, 2'h0);
    cmd(16'h0042, 8'h33, 2'h2);
    chk(nfw, 32'h0000_0002);
    chk({24'h0, fd}, 32'h0000_0033);
    apb(1, 12'h008, 32'h0000_0001);
    cmd(16'h00b2, 8'h01, 2'h0);
    rd(16'h00b2, 32'h0000_0000);
  endtask : t_post
  initial
  begin
    #20000;
    mismatches++;
    complete_run;
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_map;
    t_erase;
    t_post;
    complete_run;
  end
endmodule : test_flash_erase_write_bank_control
